// ### include/hw_config_pkg.sv
// Behaviour
// [R1] the register reads at command code 20h, writes at code A0h, 16 bits, all read/write; the code also takes writes at 20h.
// [R2] reset loads bits 5 and 3 with one and every other bit with zero.
// [R3] bit 15 set holds both sleep/wake pins high and ignores a low level on them as wakeup.
// [R4] bit 14 set puts the port 1 transceiver into low power while suspended.
// [R5] bit 13 connects the port 2 data line pull-downs when one, disconnects them when zero.
// [R6] bit 12 drives the port 1 pull-downs only when the strap is high and the id pin is low.
// [R7] with the strap low the port 1 pull-downs follow the two local pull-down control bits.
// [R8] bit 11 zero lets the clock stop in suspend, one keeps it running.
// [R9] bit 10 selects the overcurrent source: zero external digital input, one on-chip detector.
// [R10] bit 9 zero sends host irq to pin a and peripheral irq to pin b, one merges both on pin a.
// [R11] bit 8 zero qualifies the dma acknowledge on set a with the read and write strobes.
// [R12] bit 7 zero uses dma set a for host and set b for peripheral, one shares set a.
// [R13] bit 6 sets the dma acknowledge polarity on set a: zero active low, one active high.
// [R14] bit 5 sets the dma request polarity on set a: zero active low, one active high.
// [R15] bits 4 to 3 hold the bus width code, only 01 meaning a 16-bit bus is valid.
// [R16] bit 2 sets irq pin a polarity and bit 1 selects level (zero) or edge (one) signalling.
// [R17] bit 0 is the global enable of irq pin a, combined with the processor enable bits.
package hw_config_pkg;

  localparam int unsigned ADDR_W = 8;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] HWCFG_RD_OFFSET  = 8'h20;
  localparam logic [7:0] HWCFG_WR_OFFSET  = 8'hA0;
  localparam logic [7:0] STATUS_OFFSET    = 8'h28;
  localparam logic [15:0] HWCFG_RESET     = 16'h0028;

  // ---------------------------------------------------------------
  // hardware_configuration fields
  // ---------------------------------------------------------------
  localparam int unsigned SLEEP_PIN_DISABLE_BIT     = 15;
  localparam int unsigned TRANSCEIVER_LOW_POWER_BIT = 14;
  localparam int unsigned PORT2_PULLDOWN_BIT        = 13;
  localparam int unsigned PORT1_PULLDOWN_BIT        = 12;
  localparam int unsigned KEEP_CLOCK_BIT            = 11;
  localparam int unsigned ONCHIP_OC_BIT             = 10;
  localparam int unsigned MERGED_IRQ_BIT            = 9;
  localparam int unsigned DMA_ACK_QUALIFY_BIT       = 8;
  localparam int unsigned MERGED_DMA_BIT            = 7;
  localparam int unsigned DMA_ACK_POLARITY_BIT      = 6;
  localparam int unsigned DMA_REQ_POLARITY_BIT      = 5;
  localparam int unsigned BUS_WIDTH_HI_BIT          = 4;
  localparam int unsigned BUS_WIDTH_LO_BIT          = 3;
  localparam int unsigned IRQ_POLARITY_BIT          = 2;
  localparam int unsigned IRQ_EDGE_BIT              = 1;
  localparam int unsigned IRQ_ENABLE_BIT            = 0;
  localparam logic [1:0]  BUS_WIDTH_16              = 2'h1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // raw pins, all asynchronous to i_clk
  typedef struct packed {
    logic dual_role_strap;
    logic id_pin;
    logic overcurrent_ext;
    logic overcurrent_onchip;
    logic host_wake_pin;
    logic periph_wake_pin;
    logic dma_ack_a;
    logic dma_ack_b;
    logic cpu_rd_n;
    logic cpu_wr_n;
  } pin_in_type;

  localparam int unsigned PIN_IN_W = $bits(pin_in_type);

  // requests from the host and peripheral cores, same clock
  typedef struct packed {
    logic host_irq;
    logic periph_irq;
    logic host_dma_req;
    logic periph_dma_req;
    logic host_suspend;
    logic periph_suspend;
    logic local_plus_pulldown;
    logic local_minus_pulldown;
  } core_in_type;

  typedef struct packed {
    logic irq_pin_a;
    logic irq_pin_b;
    logic dma_request_a;
    logic dma_request_b;
    logic host_wake_o;
    logic host_wake_oe;
    logic periph_wake_o;
    logic periph_wake_oe;
    logic port1_plus_pulldown;
    logic port1_minus_pulldown;
    logic port2_pulldown;
  } pin_out_type;

  typedef struct packed {
    logic host_dma_ack;
    logic periph_dma_ack;
    logic host_wake_req;
    logic periph_wake_req;
    logic transceiver_low_power;
    logic clock_stop_allow;
    logic overcurrent;
  } core_out_type;

endpackage : hw_config_pkg

// ### sim/hw_config_register_checker.sv
`timescale 1ns/1ps
module hw_config_register_checker (
  // clock and reset
  input wire logic                              i_clk,
  input wire logic                              i_rstn,
  // wishbone slave
  input wire logic                              i_wb_cyc,
  input wire logic                              i_wb_stb,
  input wire logic                              i_wb_we,
  input wire logic [hw_config_pkg::ADDR_W-1:0]  i_wb_adr,
  input wire logic [3:0]                        i_wb_sel,
  input wire logic [31:0]                       i_wb_dat,
  input wire logic [31:0]                       o_wb_dat,
  input wire logic                              o_wb_ack,
  // cores and pins
  input wire hw_config_pkg::core_in_type        i_core,
  input wire hw_config_pkg::pin_out_type        o_pins,
  input wire hw_config_pkg::core_out_type       o_core,
  input wire logic [15:0]                       o_hardware_configuration
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_wr_word;
    s_req ##0 (i_wb_we && i_wb_adr == 8'h20 && i_wb_sel[1:0] == 2'h3);
  endsequence

  a_ack_after_req: assert property (s_req |=> o_wb_ack)
    else $error("request not acknowledged next cycle");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_write_lands: assert property (
    s_wr_word |=> o_hardware_configuration == $past(i_wb_dat[15:0]))
    else $error("write data not stored");
  a_read_data: assert property (
    o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == 8'h20
    |-> o_wb_dat == {16'h0000, o_hardware_configuration})
    else $error("read data differs from register");
  a_reset_load: assert property (
    disable iff (1'b0) !i_rstn |=> o_hardware_configuration == 16'h0028)
    else $error("reset value wrong");
  a_port2_follow: assert property (
    $past(i_rstn) |-> o_pins.port2_pulldown == $past(o_hardware_configuration[13]))
    else $error("port 2 pull-down wrong");
  a_sleep_hold: assert property (
    $past(i_rstn) && $past(o_hardware_configuration[15])
    |-> o_pins.host_wake_o && o_pins.periph_wake_oe && !o_core.host_wake_req)
    else $error("sleep pins not held");
  a_low_power: assert property (
    $past(i_rstn) |-> o_core.transceiver_low_power ==
    $past(o_hardware_configuration[14] && (i_core.host_suspend || i_core.periph_suspend)))
    else $error("low power wrong");
  a_clock_keep: assert property (
    $past(i_rstn) && $past(o_hardware_configuration[11]) |-> !o_core.clock_stop_allow)
    else $error("clock stop allowed");
  a_irq_merge: assert property (
    $past(i_rstn) && $past(o_hardware_configuration[9])
    |-> o_pins.irq_pin_b == !$past(o_hardware_configuration[2]))
    else $error("second irq pin not idle");
  a_dma_merge: assert property (
    $past(i_rstn) && $past(o_hardware_configuration[7]) |-> !o_pins.dma_request_b)
    else $error("second dma request used");
  a_irq_off: assert property (
    $past(i_rstn) && !$past(o_hardware_configuration[0])
    |-> o_pins.irq_pin_a == !$past(o_hardware_configuration[2]))
    else $error("irq pin active while disabled");
endmodule : hw_config_register_checker

bind hw_config_register hw_config_register_checker u_chk (
  .i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .i_core, .o_pins, .o_core, .o_hardware_configuration
);

// ### sim/hw_config_register_tb.sv
`timescale 1ns/1ps
module hw_config_register_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] cfg;
  logic [15:0] v;
  logic [31:0] r;
  logic [17:0] x;
  logic [15:0] st;
  int miscompares = 0;
  int total_checks = 0;
  hw_config_pkg::pin_in_type pw = 10'h3C0;
  hw_config_pkg::pin_in_type pt;
  hw_config_pkg::core_in_type cw = 8'h00;
  hw_config_pkg::pin_in_type pins;
  hw_config_pkg::core_in_type core;
  hw_config_pkg::pin_out_type opins;
  hw_config_pkg::core_out_type ocore;

  always #2.5 clk = ~clk;

  hw_far_side_model far (.i_clk(clk), .i_pin_want(pw), .i_core_want(cw), .o_pins(pins),
                         .o_core(core));
  hw_config_register dut (.i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_pins(pins), .o_pins(opins), .i_core(core), .o_core(ocore),
    .o_hardware_configuration(cfg));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  function automatic logic [17:0] exp_out(input logic [15:0] g,
      input hw_config_pkg::pin_in_type p, input hw_config_pkg::core_in_type c);
    hw_config_pkg::pin_out_type e;
    hw_config_pkg::core_out_type f;
    logic a;
    logic b;
    logic q;
    logic s;
    s = c.host_suspend | c.periph_suspend;
    // edge mode: a steady source leaves the pin idle once the pulse is over
    a = (c.host_irq | (g[9] & c.periph_irq)) & g[0] & ~g[1];
    b = c.periph_irq & g[0] & ~g[1] & ~g[9];
    q = g[7] ? (c.host_dma_req | c.periph_dma_req) : c.host_dma_req;
    e.irq_pin_a = g[2] ? a : ~a;
    e.irq_pin_b = g[2] ? b : ~b;
    e.dma_request_a = g[5] ? q : ~q;
    e.dma_request_b = c.periph_dma_req & ~g[7];
    e.host_wake_o = g[15];
    e.host_wake_oe = g[15] | c.host_suspend;
    e.periph_wake_o = g[15];
    e.periph_wake_oe = g[15] | c.periph_suspend;
    e.port1_plus_pulldown = p.dual_role_strap ? g[12] & ~p.id_pin : c.local_plus_pulldown;
    e.port1_minus_pulldown = p.dual_role_strap ? g[12] & ~p.id_pin : c.local_minus_pulldown;
    e.port2_pulldown = g[13];
    a = (p.dma_ack_a == g[6]) & (~p.cpu_rd_n | ~p.cpu_wr_n);
    f.host_dma_ack = a & (~g[7] | c.host_dma_req);
    f.periph_dma_ack = g[7] ? (a & ~c.host_dma_req & c.periph_dma_req) : ~p.dma_ack_b;
    f.host_wake_req = ~g[15] & ~p.host_wake_pin & ~c.host_suspend;
    f.periph_wake_req = ~g[15] & ~p.periph_wake_pin & ~c.periph_suspend;
    f.transceiver_low_power = g[14] & s;
    f.clock_stop_allow = ~g[11] & s;
    f.overcurrent = g[10] ? p.overcurrent_onchip : p.overcurrent_ext;
    return {e, f};
  endfunction : exp_out

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hfeb5efcb));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wb(1'b0, 8'h20, 4'h3, 32'h0000_0000, r);
    chk("cfg_reset", r, 32'h0000_0028);
    chk("outs_reset", {opins, ocore}, exp_out(16'h0028, pins, core));
    wb(1'b1, 8'h40, 4'hF, 32'h0000_FFFF, r);
    wb(1'b0, 8'h40, 4'h3, 32'h0000_0000, r);
    chk("unmapped", r, 32'h0000_0000);
    wb(1'b0, 8'hA0, 4'h3, 32'h0000_0000, r);
    chk("write_code_read", r, 32'h0000_0000);
    wb(1'b1, 8'h20, 4'h1, 32'hFFFF_FF0B, r);
    wb(1'b0, 8'h20, 4'h3, 32'h0000_0000, r);
    chk("low_lane", r, 32'h0000_000B);
    for (int k = 0; k < 24; k++) begin
      v = 16'($urandom());
      v[4:3] = 2'h1;
      v[8] = 1'b0;
      wb(1'b1, (k % 2) ? 8'hA0 : 8'h20, 4'hF, {16'($urandom()), v}, r);
      pt = hw_config_pkg::pin_in_type'(10'($urandom()));
      pw <= pt;
      cw <= hw_config_pkg::core_in_type'(8'($urandom()));
      wb(1'b0, 8'h20, 4'h3, 32'h0000_0000, r);
      chk("cfg_read", r, {16'h0000, v});
      chk("cfg_port", cfg, v);
      repeat (6) @(posedge clk);
      x = exp_out(v, pins, core);
      chk("outs", {opins, ocore}, x);
      // status word: width flag clear, then strap, id and live pin levels
      st = {7'h00, pins.dual_role_strap, pins.id_pin, x[0], x[4], x[3], x[9], x[8], x[17], x[16]};
      wb(1'b0, 8'h28, 4'h3, 32'h0000_0000, r);
      chk("status", r, {16'h0000, st});
    end
    print_verdict();
  end
endmodule : hw_config_register_tb

// ### sim/hw_far_side_model.sv
`timescale 1ns/1ps
module hw_far_side_model (
  // clock
  input  wire logic                        i_clk,
  // levels wanted by the bench
  input  wire hw_config_pkg::pin_in_type   i_pin_want,
  input  wire hw_config_pkg::core_in_type  i_core_want,
  // levels seen by the block
  output hw_config_pkg::pin_in_type        o_pins,
  output hw_config_pkg::core_in_type       o_core
);
  // pins move only after an edge, like a real board behind a register
  always_ff @(posedge i_clk) begin
    o_pins <= i_pin_want;
    o_core <= i_core_want;
  end
endmodule : hw_far_side_model

// ### src/hw_config_register.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
module hw_config_register (
  // clock and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_rstn,
  // wishbone slave
  input  wire logic                               i_wb_cyc,
  input  wire logic                               i_wb_stb,
  input  wire logic                               i_wb_we,
  input  wire logic [hw_config_pkg::ADDR_W-1:0]   i_wb_adr,
  input  wire logic [3:0]                         i_wb_sel,
  input  wire logic [31:0]                        i_wb_dat,
  output logic      [31:0]                        o_wb_dat,
  output logic                                    o_wb_ack,
  // device pins
  input  wire hw_config_pkg::pin_in_type          i_pins,
  output hw_config_pkg::pin_out_type              o_pins,
  // host and peripheral cores
  input  wire hw_config_pkg::core_in_type         i_core,
  output hw_config_pkg::core_out_type             o_core,
  // whole configuration word for the cores
  output logic      [15:0]                        o_hardware_configuration
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0]                hardware_configuration;
    logic                       ack;
    logic [31:0]                rdata;
    logic                       irq_src_a_last;
    logic                       irq_src_b_last;
    hw_config_pkg::pin_out_type pins;
    hw_config_pkg::core_out_type core;
  } state_type;

  state_type                  state;
  state_type                  next_state;
  hw_config_pkg::pin_in_type  pin_sync;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  pin_sync2 #(
    .WIDTH (hw_config_pkg::PIN_IN_W)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (i_pins),
    .o_sync  (pin_sync)
  );

  // ---------------------------------------------------------------
  // decoded fields
  // ---------------------------------------------------------------
  logic [15:0] cfg;
  logic        bus_req;
  logic        hit_rd;
  logic        hit_wr;
  logic        hit_status;
  logic [15:0] status_word;

  assign cfg        = state.hardware_configuration;
  assign bus_req    = i_wb_cyc && i_wb_stb && !state.ack;
  assign hit_rd     = i_wb_adr == hw_config_pkg::HWCFG_RD_OFFSET;
  assign hit_wr     = i_wb_adr == hw_config_pkg::HWCFG_WR_OFFSET;
  assign hit_status = i_wb_adr == hw_config_pkg::STATUS_OFFSET;

  // live state seen by software, read only
  assign status_word = {
    6'h00,
    cfg[hw_config_pkg::BUS_WIDTH_HI_BIT:hw_config_pkg::BUS_WIDTH_LO_BIT]
      != hw_config_pkg::BUS_WIDTH_16,
    pin_sync.dual_role_strap,
    pin_sync.id_pin,
    state.core.overcurrent,
    state.core.host_wake_req,
    state.core.periph_wake_req,
    state.pins.port1_plus_pulldown,
    state.pins.port1_minus_pulldown,
    state.pins.irq_pin_a,
    state.pins.irq_pin_b
  };

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic any_suspend;
  logic irq_src_a;
  logic irq_src_b;
  logic irq_act_a;
  logic irq_act_b;
  logic ack_a_active;
  logic ack_b_active;
  logic strobe_active;
  logic ack_a_qual;
  logic dreq_a_active;

  always_comb begin
    next_state = state;

    // register bus: one wait cycle, ack for one cycle
    next_state.ack   = bus_req;
    next_state.rdata = 32'h0000_0000;
    if (bus_req) begin
      if (i_wb_we && (hit_rd || hit_wr)) begin // R1
        if (i_wb_sel[0]) begin
          next_state.hardware_configuration[7:0] = i_wb_dat[7:0];
        end
        if (i_wb_sel[1]) begin
          next_state.hardware_configuration[15:8] = i_wb_dat[15:8];
        end
      end
      if (!i_wb_we && hit_rd) begin // R1
        next_state.rdata = {16'h0000, cfg};
      end
      if (!i_wb_we && hit_status) begin
        next_state.rdata = {16'h0000, status_word};
      end
    end

    // sleep/wake pins
    any_suspend = i_core.host_suspend || i_core.periph_suspend;
    if (cfg[hw_config_pkg::SLEEP_PIN_DISABLE_BIT]) begin // R3
      next_state.pins.host_wake_o     = 1'b1;
      next_state.pins.host_wake_oe    = 1'b1;
      next_state.pins.periph_wake_o   = 1'b1;
      next_state.pins.periph_wake_oe  = 1'b1;
      next_state.core.host_wake_req   = 1'b0;
      next_state.core.periph_wake_req = 1'b0;
    end else begin
      // released: the pins show suspend as a low level when driven
      next_state.pins.host_wake_o     = 1'b0;
      next_state.pins.host_wake_oe    = i_core.host_suspend;
      next_state.pins.periph_wake_o   = 1'b0;
      next_state.pins.periph_wake_oe  = i_core.periph_suspend;
      next_state.core.host_wake_req   = !pin_sync.host_wake_pin && !i_core.host_suspend;
      next_state.core.periph_wake_req = !pin_sync.periph_wake_pin && !i_core.periph_suspend;
    end

    // power and clock
    next_state.core.transceiver_low_power =
      cfg[hw_config_pkg::TRANSCEIVER_LOW_POWER_BIT] && any_suspend; // R4
    next_state.core.clock_stop_allow =
      !cfg[hw_config_pkg::KEEP_CLOCK_BIT] && any_suspend; // R8

    // pull-downs
    next_state.pins.port2_pulldown = cfg[hw_config_pkg::PORT2_PULLDOWN_BIT]; // R5
    if (!pin_sync.dual_role_strap) begin
      next_state.pins.port1_plus_pulldown  = i_core.local_plus_pulldown; // R7
      next_state.pins.port1_minus_pulldown = i_core.local_minus_pulldown; // R7
    end else if (!pin_sync.id_pin) begin
      next_state.pins.port1_plus_pulldown  = cfg[hw_config_pkg::PORT1_PULLDOWN_BIT]; // R6
      next_state.pins.port1_minus_pulldown = cfg[hw_config_pkg::PORT1_PULLDOWN_BIT]; // R6
    end else begin
      // peripheral role: pull-downs stay off
      next_state.pins.port1_plus_pulldown  = 1'b0;
      next_state.pins.port1_minus_pulldown = 1'b0;
    end

    // overcurrent source
    next_state.core.overcurrent = cfg[hw_config_pkg::ONCHIP_OC_BIT] ?
      pin_sync.overcurrent_onchip : pin_sync.overcurrent_ext; // R9

    // ---------------------------------------------------------------
    // interrupt pins
    // ---------------------------------------------------------------
    if (cfg[hw_config_pkg::MERGED_IRQ_BIT]) begin // R10
      irq_src_a = i_core.host_irq || i_core.periph_irq;
      irq_src_b = 1'b0;
    end else begin
      irq_src_a = i_core.host_irq;
      irq_src_b = i_core.periph_irq;
    end
    // the cores hand in irqs already gated by their own enable bits
    irq_src_a = irq_src_a && cfg[hw_config_pkg::IRQ_ENABLE_BIT]; // R17
    irq_src_b = irq_src_b && cfg[hw_config_pkg::IRQ_ENABLE_BIT];
    next_state.irq_src_a_last = irq_src_a;
    next_state.irq_src_b_last = irq_src_b;
    // edge mode gives a one-cycle pulse on each rise of the source
    if (cfg[hw_config_pkg::IRQ_EDGE_BIT]) begin // R16
      irq_act_a = irq_src_a && !state.irq_src_a_last;
      irq_act_b = irq_src_b && !state.irq_src_b_last;
    end else begin
      irq_act_a = irq_src_a;
      irq_act_b = irq_src_b;
    end
    next_state.pins.irq_pin_a = cfg[hw_config_pkg::IRQ_POLARITY_BIT] ?
      irq_act_a : !irq_act_a; // R16
    next_state.pins.irq_pin_b = cfg[hw_config_pkg::IRQ_POLARITY_BIT] ? irq_act_b : !irq_act_b;

    // ---------------------------------------------------------------
    // dma pins
    // ---------------------------------------------------------------
    ack_a_active  = cfg[hw_config_pkg::DMA_ACK_POLARITY_BIT] ?
      pin_sync.dma_ack_a : !pin_sync.dma_ack_a; // R13
    ack_b_active  = !pin_sync.dma_ack_b;
    strobe_active = !pin_sync.cpu_rd_n || !pin_sync.cpu_wr_n;
    // reserved mode one passes the acknowledge unqualified
    ack_a_qual    = cfg[hw_config_pkg::DMA_ACK_QUALIFY_BIT] ?
      ack_a_active : ack_a_active && strobe_active; // R11

    if (cfg[hw_config_pkg::MERGED_DMA_BIT]) begin // R12
      dreq_a_active = i_core.host_dma_req || i_core.periph_dma_req;
      next_state.pins.dma_request_b = 1'b0;
      // host wins a shared acknowledge when both request
      next_state.core.host_dma_ack   = ack_a_qual && i_core.host_dma_req;
      next_state.core.periph_dma_ack =
        ack_a_qual && !i_core.host_dma_req && i_core.periph_dma_req;
    end else begin
      dreq_a_active = i_core.host_dma_req;
      next_state.pins.dma_request_b  = i_core.periph_dma_req;
      next_state.core.host_dma_ack   = ack_a_qual;
      next_state.core.periph_dma_ack = ack_b_active;
    end
    next_state.pins.dma_request_a = cfg[hw_config_pkg::DMA_REQ_POLARITY_BIT] ?
      dreq_a_active : !dreq_a_active; // R14

    // ---------------------------------------------------------------
    // reset
    // ---------------------------------------------------------------
    if (!i_rstn) begin
      next_state = '0;
      next_state.hardware_configuration = hw_config_pkg::HWCFG_RESET; // R2
      next_state.pins.irq_pin_a     = 1'b1;
      next_state.pins.irq_pin_b     = 1'b1;
      next_state.pins.dma_request_a = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    state <= next_state;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // width code is stored as written; a bad code shows in status bit 9
  assign o_hardware_configuration = state.hardware_configuration; // R15
  assign o_wb_ack                 = state.ack;
  assign o_wb_dat                 = state.rdata;
  assign o_pins                   = state.pins;
  assign o_core                   = state.core;

endmodule : hw_config_register

// ### src/pin_sync2.sv
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // first stage feeds only the second stage
  always_comb begin
    next_state.meta = i_async;
    next_state.sync = state.meta;
    if (!i_rstn) begin
      next_state = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    state <= next_state;
  end

  assign o_sync = state.sync;

endmodule : pin_sync2
